// ### hw/spt_pkg.sv
// constants, register layouts and types of the serial port transmit control
package spt_pkg;
   // register byte offsets
   localparam logic [7:0] SPT_OFS_TSC    = 8'h00;
   localparam logic [7:0] SPT_OFS_PCTL   = 8'h04;
   localparam logic [7:0] SPT_OFS_BAUD   = 8'h08;
   localparam logic [7:0] SPT_OFS_DATA   = 8'h0c;
   // reset values
   localparam logic [7:0]  SPT_TSC_RST   = 8'h02;
   localparam logic [7:0]  SPT_PCTL_RST  = 8'h00;
   localparam logic [15:0] SPT_BAUD_RST  = 16'h0000;
   // bit-period division per baud tick
   localparam logic [6:0] SPT_DIV_LOW    = 7'h40;
   localparam logic [6:0] SPT_DIV_HIGH   = 7'h10;
   localparam logic [6:0] SPT_DIV_SYNC   = 7'h02;
   // frame lengths in bits
   localparam logic [3:0] SPT_LEN_A8     = 4'ha;
   localparam logic [3:0] SPT_LEN_A9     = 4'hb;
   localparam logic [3:0] SPT_LEN_BRK    = 4'hd;
   localparam logic [3:0] SPT_LEN_S8     = 4'h8;
   localparam logic [3:0] SPT_LEN_S9     = 4'h9;
   localparam logic [12:0] SPT_BRK_FRAME = 13'h1000;
   // axi responses
   localparam logic [1:0] SPT_RESP_OKAY  = 2'h0;
   localparam logic [1:0] SPT_RESP_SLV   = 2'h2;

   typedef struct packed {
      logic clock_source_sel;
      logic tx_nine_bit_sel;
      logic tx_enable;
      logic sync_mode;
      logic break_request;
      logic speed_select;
      logic shift_empty_flag;
      logic tx_ninth_data;
   } spt_tsc_t;

   typedef struct packed {
      logic port_enable;
      logic tx_open_drain_sel;
      logic single_rx_enable;
      logic continuous_rx_enable;
      logic clock_idle_high;
      logic unused;
      logic port_c_dir7;
      logic port_c_dir6;
   } spt_pctl_t;

   // one shared pin: level driven, enable (low drives)
   typedef struct packed {
      logic dout;
      logic oe_n;
   } spt_pin_t;

   typedef enum logic {
      SPT_ST_IDLE = 1'b0,
      SPT_ST_SEND = 1'b1
   } spt_state_t;
endpackage : spt_pkg

// ### hw/spt_tx_ctrl.sv
// serial port transmit control with axi4-lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module spt_tx_ctrl #(
   parameter int FIFO_DEPTH = 2
) (
   // system
   input  wire logic              SYS_CLK_I,
   input  wire logic              SYS_RST_I,
   // axi4-lite write
   input  wire logic [7:0]        S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   // axi4-lite read
   input  wire logic [7:0]        S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I,
   // transmit / sync clock pin
   input  wire logic              TX_CK_I,
   output spt_pkg::spt_pin_t      TX_CK_O,
   // receive / sync data pin
   input  wire logic              RX_DT_I,
   output spt_pkg::spt_pin_t      RX_DT_O
);
   import spt_pkg::*;

   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

   spt_tsc_t         tsc;
   spt_pctl_t        pctl;
   logic [15:0]      baud_div;
   spt_state_t       state;
   logic [7:0]       fifo_mem [FIFO_DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      fifo_cnt;
   logic             aw_held;
   logic             w_held;
   logic [7:0]       wr_addr;
   logic [31:0]      wr_data;
   logic [3:0]       wr_strb;
   logic [15:0]      baud_timer;
   logic [6:0]       sub_cnt;
   logic [12:0]      shift_reg;
   logic [3:0]       bits_left;
   logic             brk_active;
   logic             clk_level;
   logic             ck_s1, ck_s2, ck_prev;
   logic             dt_s1, dt_s2;

   ////////////////////////////////////////////////////////////////////////////
   // register bus decode
   logic fifo_full, fifo_valid, do_write, wr_is_data, wr_tsc, wr_pctl, wr_baud;
   logic push, pop;
   assign fifo_full       = (fifo_cnt == (PW+1)'(FIFO_DEPTH));
   assign fifo_valid      = (fifo_cnt != '0);
   assign wr_is_data      = (wr_addr == SPT_OFS_DATA);
   // a data write waits while the buffer is full, stalling the bus
   assign do_write        = aw_held && w_held && !S_AXI_BVALID_O && !(wr_is_data && fifo_full);
   assign wr_tsc          = do_write && (wr_addr == SPT_OFS_TSC) && wr_strb[0];
   assign wr_pctl         = do_write && (wr_addr == SPT_OFS_PCTL) && wr_strb[0];
   assign wr_baud         = do_write && (wr_addr == SPT_OFS_BAUD);
   assign push            = do_write && wr_is_data && wr_strb[0];
   assign S_AXI_AWREADY_O = !aw_held;
   assign S_AXI_WREADY_O  = !w_held;
   assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         aw_held <= 1'b0;
         wr_addr <= '0;
      end else if (S_AXI_AWVALID_I && !aw_held) begin
         aw_held <= 1'b1;
         wr_addr <= {S_AXI_AWADDR_I[7:2], 2'b00};
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         w_held  <= 1'b0;
         wr_data <= '0;
         wr_strb <= '0;
      end else if (S_AXI_WVALID_I && !w_held) begin
         w_held  <= 1'b1;
         wr_data <= S_AXI_WDATA_I;
         wr_strb <= S_AXI_WSTRB_I;
      end else if (do_write) begin
         w_held  <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= SPT_RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID_O <= 1'b1;
         S_AXI_BRESP_O  <= (wr_addr > SPT_OFS_DATA) ? SPT_RESP_SLV : SPT_RESP_OKAY;
      end else if (S_AXI_BREADY_I) begin
         S_AXI_BVALID_O <= 1'b0;
      end
   end

   logic [7:0] rd_addr;
   assign rd_addr = {S_AXI_ARADDR_I[7:2], 2'b00};
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         S_AXI_RVALID_O <= 1'b0;
         S_AXI_RDATA_O  <= '0;
         S_AXI_RRESP_O  <= SPT_RESP_OKAY;
      end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
         S_AXI_RVALID_O <= 1'b1;
         S_AXI_RRESP_O  <= SPT_RESP_OKAY;
         unique case (rd_addr)
            SPT_OFS_TSC:  S_AXI_RDATA_O <= {24'h000000, tsc};
            SPT_OFS_PCTL: S_AXI_RDATA_O <= {24'h000000, pctl};
            SPT_OFS_BAUD: S_AXI_RDATA_O <= {16'h0000, baud_div};
            SPT_OFS_DATA: S_AXI_RDATA_O <= {26'h0000000, dt_s2, ck_s2, brk_active,
                                            (state == SPT_ST_SEND), fifo_valid, !fifo_full};
            default: begin
               S_AXI_RDATA_O <= '0;
               S_AXI_RRESP_O <= SPT_RESP_SLV;
            end
         endcase
      end else if (S_AXI_RREADY_I) begin
         S_AXI_RVALID_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic brk_done, step, last_bit;
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         tsc <= SPT_TSC_RST;
      end else begin
         if (wr_tsc) begin
            tsc.clock_source_sel <= wr_data[7];
            tsc.tx_nine_bit_sel  <= wr_data[6];
            tsc.tx_enable        <= wr_data[5];
            tsc.sync_mode        <= wr_data[4];
            tsc.break_request    <= wr_data[3];
            tsc.speed_select     <= wr_data[2];
            tsc.tx_ninth_data    <= wr_data[0];
         end
         // a fresh request written in the completing cycle survives
         if (brk_done && !(wr_tsc && wr_data[3]))
            tsc.break_request <= 1'b0;
         tsc.shift_empty_flag <= (state == SPT_ST_IDLE) && !pop ||
                                 (state == SPT_ST_SEND) && step && last_bit;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I)
         pctl <= SPT_PCTL_RST;
      else if (wr_pctl)
         pctl <= wr_data[7:0];
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I)
         baud_div <= SPT_BAUD_RST;
      else if (wr_baud) begin
         if (wr_strb[0]) baud_div[7:0]  <= wr_data[7:0];
         if (wr_strb[1]) baud_div[15:8] <= wr_data[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-entry transmit buffer
   logic eng_rst;
   assign eng_rst = SYS_RST_I || !pctl.port_enable;

   always_ff @(posedge SYS_CLK_I) begin
      if (push)
         fifo_mem[wr_ptr] <= wr_data[7:0];
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (eng_rst) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         fifo_cnt <= '0;
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         fifo_cnt <= fifo_cnt + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // baud timing and clock-pin synchroniser
   logic       master, rx_override, can_tx, tick, half_evt, slave_edge;
   logic [6:0] sub_lim;
   assign master      = tsc.sync_mode && tsc.clock_source_sel;
   assign rx_override = tsc.sync_mode && (pctl.single_rx_enable || pctl.continuous_rx_enable);
   assign can_tx      = tsc.tx_enable && !rx_override;
   assign sub_lim     = tsc.sync_mode ? SPT_DIV_SYNC :
                        (tsc.speed_select ? SPT_DIV_HIGH : SPT_DIV_LOW);
   assign tick        = (baud_timer == baud_div);
   assign half_evt    = tick && (sub_cnt == sub_lim - 7'h01);

   always_ff @(posedge SYS_CLK_I) begin
      if (eng_rst || wr_baud || state == SPT_ST_IDLE) begin
         baud_timer <= '0;
         sub_cnt    <= '0;
      end else if (tick) begin
         baud_timer <= '0;
         sub_cnt    <= half_evt ? 7'h00 : sub_cnt + 7'h01;
      end else begin
         baud_timer <= baud_timer + 16'h0001;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         // start the clock samples at the pulled-up idle level so no false edge follows reset; data samples start low
         ck_s1   <= 1'b1;
         ck_s2   <= 1'b1;
         ck_prev <= 1'b1;
         dt_s1   <= 1'b0;
         dt_s2   <= 1'b0;
      end else begin
         ck_s1   <= TX_CK_I;
         ck_s2   <= ck_s1;
         ck_prev <= ck_s2;
         dt_s1   <= RX_DT_I;
         dt_s2   <= dt_s1;
      end
   end
   // slave shifts on the edge that returns the clock to its idle level
   assign slave_edge = (ck_prev != pctl.clock_idle_high) && (ck_s2 == pctl.clock_idle_high);

   ////////////////////////////////////////////////////////////////////////////
   // shift engine
   assign pop      = (state == SPT_ST_IDLE) && can_tx && fifo_valid;
   assign last_bit = (bits_left == 4'h1);
   assign step     = !tsc.sync_mode ? half_evt :
                     master ? (half_evt && (clk_level != pctl.clock_idle_high)) : slave_edge;
   assign brk_done = (state == SPT_ST_SEND) && step && last_bit && brk_active;

   always_ff @(posedge SYS_CLK_I) begin
      if (eng_rst) begin
         state      <= SPT_ST_IDLE;
         shift_reg  <= '1;
         bits_left  <= '0;
         brk_active <= 1'b0;
      end else begin
         unique case (state)
            SPT_ST_IDLE: begin
               if (pop) begin
                  state      <= SPT_ST_SEND;
                  brk_active <= tsc.break_request && !tsc.sync_mode;
                  if (tsc.sync_mode) begin
                     shift_reg <= {4'h0, tsc.tx_ninth_data, fifo_mem[rd_ptr]};
                     bits_left <= tsc.tx_nine_bit_sel ? SPT_LEN_S9 : SPT_LEN_S8;
                  end else if (tsc.break_request) begin
                     shift_reg <= SPT_BRK_FRAME;
                     bits_left <= SPT_LEN_BRK;
                  end else if (tsc.tx_nine_bit_sel) begin
                     shift_reg <= {3'h7, tsc.tx_ninth_data, fifo_mem[rd_ptr], 1'b0};
                     bits_left <= SPT_LEN_A9;
                  end else begin
                     shift_reg <= {4'hf, fifo_mem[rd_ptr], 1'b0};
                     bits_left <= SPT_LEN_A8;
                  end
               end
            end
            SPT_ST_SEND: begin
               if (!can_tx) begin
                  state      <= SPT_ST_IDLE;
                  shift_reg  <= '1;
                  brk_active <= 1'b0;
               end else if (step) begin
                  shift_reg <= {1'b1, shift_reg[12:1]};
                  bits_left <= bits_left - 4'h1;
                  if (last_bit) begin
                     state      <= SPT_ST_IDLE;
                     brk_active <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (eng_rst)
         clk_level <= 1'b0;
      else if (state == SPT_ST_IDLE || !master)
         clk_level <= pctl.clock_idle_high;
      else if (half_evt)
         clk_level <= !clk_level;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers
   logic pins_ok, line;
   assign pins_ok = pctl.port_enable && pctl.port_c_dir7 && pctl.port_c_dir6;
   assign line    = (state == SPT_ST_SEND) ? shift_reg[0] : 1'b1;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         TX_CK_O <= '{dout: 1'b1, oe_n: 1'b1};
         RX_DT_O <= '{dout: 1'b1, oe_n: 1'b1};
      end else if (!pins_ok) begin
         TX_CK_O <= '{dout: 1'b1, oe_n: 1'b1};
         RX_DT_O <= '{dout: 1'b1, oe_n: 1'b1};
      end else if (!tsc.sync_mode) begin
         // full duplex: transmit pin driven, receive pin left as input
         if (pctl.tx_open_drain_sel)
            TX_CK_O <= '{dout: 1'b0, oe_n: line};
         else
            TX_CK_O <= '{dout: line, oe_n: 1'b0};
         RX_DT_O <= '{dout: 1'b1, oe_n: 1'b1};
      end else begin
         // half duplex: data pin turned around by the port itself
         TX_CK_O <= '{dout: clk_level, oe_n: !master};
         RX_DT_O <= '{dout: line, oe_n: !(state == SPT_ST_SEND)};
      end
   end
endmodule : spt_tx_ctrl
`default_nettype wire

// ### verification/spt_sva.sv
// bus and pin checker for the serial port transmit control
`timescale 1ns/1ns
`default_nettype none
module spt_chk
   import spt_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
) (
   // system
   input wire logic        SYS_CLK_I,
   input wire logic        SYS_RST_I,
   // axi4-lite write
   input wire logic [7:0]  S_AXI_AWADDR_I,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic [1:0]  S_AXI_BRESP_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic        S_AXI_BREADY_I,
   // axi4-lite read
   input wire logic [7:0]  S_AXI_ARADDR_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0]  S_AXI_RRESP_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   // pins
   input wire spt_pkg::spt_pin_t TX_CK_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   ////////////////////////////////////////////////////////////////////////////
   // address and data taken at the same edge
   wire logic both_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   wire logic ar_hs   = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   ////////////////////////////////////////////////////////////////////////////
   a_reset_idle: assert property ($fell(SYS_RST_I) |-> !S_AXI_BVALID_O && !S_AXI_RVALID_O
      && S_AXI_AWREADY_O && TX_CK_O.oe_n) else $error("outputs not idle after reset");
   a_read_answer: assert property (ar_hs |=> S_AXI_RVALID_O) else $error("read not answered");
   a_unmapped_rd: assert property (ar_hs && S_AXI_ARADDR_I > 8'h0f |=>
      S_AXI_RRESP_O == SPT_RESP_SLV && S_AXI_RDATA_O == 32'h0) else $error("unmapped read answer");
   a_rdata_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O)) else $error("read answer moved");
   a_bresp_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer moved");
   a_write_answer: assert property (both_hs && S_AXI_AWADDR_I[7:2] != 6'h03 |->
      ##[1:2] S_AXI_BVALID_O) else $error("write not answered");
   a_unmapped_wr: assert property (both_hs && S_AXI_AWADDR_I > 8'h0f |->
      ##[1:2] (S_AXI_BVALID_O && S_AXI_BRESP_O == SPT_RESP_SLV)) else $error("unmapped write answer");
   a_bvalid_once: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write answered twice");
   a_rvalid_once: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
      else $error("read answered twice");
endmodule : spt_chk

bind spt_tx_ctrl spt_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.SYS_CLK_I, .SYS_RST_I, .S_AXI_AWADDR_I,
   .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
   .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
   .S_AXI_RVALID_O, .S_AXI_RREADY_I, .TX_CK_O);
`default_nettype wire

// ### verification/spt_term.sv
// remote serial terminal: decodes asynchronous frames seen on the transmit line
`timescale 1ns/1ns
`default_nettype none
module spt_term (
   input  wire logic        clk,
   input  wire logic        line,
   input  wire logic [7:0]  bit_clks,
   input  wire logic [3:0]  nbits,
   output logic             rx_line,
   output logic [12:0]      frame,
   output logic [7:0]       cnt
);
   logic [12:0] f;
   // terminal sends nothing: its line idles high
   initial begin
      rx_line = 1'b1;
      cnt = 8'h00;
      frame = 13'h0;
      forever begin
         @(negedge line);
         f = 13'h0;
         repeat (bit_clks / 2) @(posedge clk);
         // data bits after the start bit, then the stop bit
         for (int i = 0; i <= nbits; i++) begin
            repeat (bit_clks) @(posedge clk);
            f[i] = line;
         end
         frame = f;
         cnt = cnt + 8'h01;
      end
   end
endmodule : spt_term
`default_nettype wire

// ### verification/testbench.sv
// register-level testbench of the serial port transmit control
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import spt_pkg::*;
   logic        clk, rst, awv, wv, bready, arv, rready;
   logic [7:0]  awaddr, araddr, bclk, n0;
   logic [31:0] wdata, d;
   logic [3:0]  nb;
   logic [1:0]  last_resp;
   wire logic   awready, wready, bvalid, arready, rvalid, rx_term;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [12:0] frame;
   wire logic [7:0]  cnt;
   spt_pin_t    tx_o, rx_o;
   int          n_fail, samples_checked;
   // lines are pulled up when released
   wire logic tx_line = (tx_o.oe_n === 1'b0) ? tx_o.dout : 1'b1;
   wire logic rx_line = (rx_o.oe_n === 1'b0) ? rx_o.dout : rx_term;

   spt_tx_ctrl #(.FIFO_DEPTH(2)) dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
      .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .TX_CK_I(tx_line), .TX_CK_O(tx_o), .RX_DT_I(rx_line), .RX_DT_O(rx_o));
   spt_term u_term (.clk(clk), .line(tx_line), .bit_clks(bclk), .nbits(nb), .rx_line(rx_term),
      .frame(frame), .cnt(cnt));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (ad && wd && bvalid === 1'b1) break;
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wv <= 1'b0;
         end
      end
      last_resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ad;
      ad = 1'b0;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (ad && rvalid === 1'b1) break;
         if (!ad && arready === 1'b1) begin
            ad = 1'b1;
            arv <= 1'b0;
         end
      end
      v = rdata;
      last_resp = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic send(input logic [7:0] v);
      n0 = cnt;
      wr(SPT_OFS_DATA, {24'h0, v});
   endtask : send

   // wait for the next decoded frame and compare it
   task automatic fin(input logic [12:0] exp);
      while (cnt == n0) @(posedge clk);
      n0 = cnt;
      chk({19'h0, frame}, {19'h0, exp});
      // let the stop bit finish so status and next settings see an idle engine
      repeat (bclk / 2 + 2) @(posedge clk);
   endtask : fin
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; bclk = 8'h10; nb = 4'h8; n0 = 8'h00;
      n_fail = 0; samples_checked = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(SPT_OFS_TSC, d); chk(d, 32'h02);
      wr(SPT_OFS_TSC, 32'h0); rd(SPT_OFS_TSC, d); chk(d, 32'h02);
      rd(SPT_OFS_PCTL, d); chk(d, 32'h0);
      rd(8'h10, d); chk(d, 32'h0); chk({30'h0, last_resp}, {30'h0, SPT_RESP_SLV});
      wr(8'h10, 32'hff); chk({30'h0, last_resp}, {30'h0, SPT_RESP_SLV});
      wr(SPT_OFS_BAUD, 32'h0);
      wr(SPT_OFS_PCTL, 32'h80); wr(SPT_OFS_TSC, 32'h24); repeat (4) @(posedge clk);
      chk(32'(tx_o.oe_n), 32'h1);
      wr(SPT_OFS_PCTL, 32'h83);
      send(8'ha5); rd(SPT_OFS_TSC, d); chk(d & 32'h2, 32'h0);
      fin(13'h1a5); rd(SPT_OFS_TSC, d); chk(d, 32'h26);
      nb = 4'h9; wr(SPT_OFS_TSC, 32'h65); send(8'h3c); fin(13'h33c);
      wr(SPT_OFS_TSC, 32'h64); send(8'hc3); fin(13'h2c3);
      nb = 4'hb; wr(SPT_OFS_TSC, 32'h2c); send(8'h00); fin(13'h800);
      rd(SPT_OFS_TSC, d); chk(d, 32'h26);
      nb = 4'h8; bclk = 8'h20; wr(SPT_OFS_BAUD, 32'h1); rd(SPT_OFS_BAUD, d); chk(d, 32'h1);
      send(8'h69); fin(13'h169); wr(SPT_OFS_BAUD, 32'h0);
      nb = 4'h8; bclk = 8'h40; wr(SPT_OFS_TSC, 32'h20); send(8'h81); fin(13'h181);
      bclk = 8'h10; wr(SPT_OFS_TSC, 32'h04); send(8'h5a); repeat (300) @(posedge clk);
      chk({24'h0, cnt}, {24'h0, n0});
      wr(SPT_OFS_TSC, 32'h24); fin(13'h15a);
      send(8'h11); wr(SPT_OFS_DATA, 32'h22); wr(SPT_OFS_DATA, 32'h33);
      rd(SPT_OFS_DATA, d); chk(d & 32'h3, 32'h2);
      fin(13'h111); fin(13'h122); fin(13'h133);
      wr(SPT_OFS_PCTL, 32'hc3); repeat (4) @(posedge clk); chk(32'(tx_o), 32'h1);
      send(8'h96); fin(13'h196); wr(SPT_OFS_PCTL, 32'h83);
      wr(SPT_OFS_TSC, 32'hb0);
      for (int p = 0; p < 2; p++) begin
         wr(SPT_OFS_PCTL, 32'h83 | (p << 3)); repeat (8) @(posedge clk);
         chk(32'(tx_o), 32'(p << 1));
      end
      wr(SPT_OFS_DATA, 32'h5a); repeat (10) @(posedge clk); chk(32'(rx_o.oe_n), 32'h0);
      wr(SPT_OFS_PCTL, 32'h93); repeat (4) @(posedge clk); chk(32'(rx_o.oe_n), 32'h1);
      wr(SPT_OFS_TSC, 32'h30); wr(SPT_OFS_PCTL, 32'h83); repeat (4) @(posedge clk);
      chk(32'(tx_o.oe_n), 32'h1);
      wr(SPT_OFS_PCTL, 32'h03); repeat (4) @(posedge clk);
      chk({30'h0, rx_o.oe_n, tx_o.oe_n}, 32'h3);
      rd(SPT_OFS_DATA, d); chk(d & 32'h3, 32'h1);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
   end
endmodule : testbench
`default_nettype wire
